// ==== hdl/mcl_pkg.sv ====
// shared constants and types for the configurable output macrocell
package mcl_pkg;

  ////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [7:0] MCL_OFS_CFG    = 8'h00;
  localparam logic [7:0] MCL_OFS_DEVICE = 8'h04;
  localparam logic [7:0] MCL_OFS_CTRL   = 8'h08;
  localparam logic [7:0] MCL_OFS_STATUS = 8'h0c;

  ////////////////////////////////////////////////////////////////////////
  // macrocell configuration field positions
  localparam int MCL_CFG_KIND_LSB = 0;
  localparam int MCL_CFG_KIND_W   = 3;
  localparam int MCL_CFG_TSEL     = 3;
  localparam int MCL_CFG_SRSEL    = 4;
  localparam int MCL_CFG_INVERT   = 5;
  localparam int MCL_CFG_OECLK    = 6;
  localparam int MCL_CFG_FB_LSB   = 7;
  localparam int MCL_CFG_FB_W     = 2;
  localparam int MCL_CFG_OUTNONE  = 9;
  localparam int MCL_CFG_SPLIT_LSB = 10;
  localparam int MCL_CFG_SPLIT_W  = 4;
  localparam int MCL_CFG_W        = 14;

  // device-wide bits
  localparam int MCL_DEV_LOCK     = 0;
  localparam int MCL_DEV_PDDIS    = 1;
  // control: write one to erase
  localparam int MCL_CTRL_ERASE   = 0;
  // status bits
  localparam int MCL_ST_Q         = 0;
  localparam int MCL_ST_PIN       = 1;
  localparam int MCL_ST_STANDBY   = 2;
  localparam int MCL_ST_OE        = 3;
  localparam int MCL_ST_OUT       = 4;

  ////////////////////////////////////////////////////////////////////////
  // operating configuration, one-hot
  typedef enum logic [2:0] {
    MCL_KIND_COMB = 3'b001,
    MCL_KIND_DT   = 3'b010,
    MCL_KIND_JKSR = 3'b100
  } mcl_kind_t;

  // feedback selector codes
  localparam logic [1:0] MCL_FB_NONE = 2'h0;
  localparam logic [1:0] MCL_FB_PIN  = 2'h1;
  localparam logic [1:0] MCL_FB_REG  = 2'h2;

  // erased defaults: combinatorial, inverted, pin feedback, mode 0
  localparam logic [3:0] MCL_SPLIT_RST = 4'h4;
  localparam logic [MCL_CFG_W-1:0] MCL_CFG_ERASED =
    {MCL_SPLIT_RST, 1'b0, MCL_FB_PIN, 1'b0, 1'b1, 1'b0, 1'b0, MCL_KIND_COMB};
  localparam logic [1:0] MCL_DEV_ERASED = 2'h0;

  ////////////////////////////////////////////////////////////////////////
  // timing
  localparam int MCL_NPT           = 8;
  localparam int MCL_CLK_PERIOD_NS = 4;
  localparam int MCL_STANDBY_NS    = 100;
  // longest idle time, rounded down to whole cycles, at least one
  localparam int MCL_STANDBY_CYC   = (MCL_STANDBY_NS / MCL_CLK_PERIOD_NS) < 1 ? 1 :
                                     (MCL_STANDBY_NS / MCL_CLK_PERIOD_NS);

endpackage

// ==== hdl/mcl_idle_timer.sv ====
// idle counter that raises standby after a quiet period
`timescale 1ns/1ns
module mcl_idle_timer
  import mcl_pkg::*;
#(
  parameter int IDLE_CYC = MCL_STANDBY_CYC
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic activity,
  input  wire logic pd_disable,
  output logic      standby
);

  localparam int CW = $clog2(IDLE_CYC + 1);
  localparam logic [CW-1:0] LAST = CW'(IDLE_CYC);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          standby;
  } mcl_idle_t;

  mcl_idle_t st;
  mcl_idle_t next_st;

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_st = st;
    if (pd_disable || activity) begin
      // any transition wakes the cell at once; disabled power-down never sleeps
      next_st.cnt     = '0;
      next_st.standby = 1'b0;
    end else if (st.cnt != LAST) begin
      next_st.cnt = st.cnt + CW'(1);
    end else begin
      next_st.standby = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign standby = st.standby;

endmodule

// ==== hdl/mcl_macrocell.sv ====
// configurable output macrocell with apb configuration registers
//
// What this block does
// - combinatorial: output is the OR of eight product terms, no register.
// - polarity bit drives output true or inverted in every configuration.
// - combinatorial: one dedicated product term drives the pin output enable.
// - combinatorial: feedback returns pin value or nothing.
// - D or T: OR of eight product terms feeds the register input.
// - registered: a dedicated product term is the register clear.
// - clear term high forces register low without clock; cleared at power-up.
// - registered: per-cell selector picks one of two enable/clock modes.
// - mode 0: term enables output, global clock; mode 1: always on, term clocks.
// - D or T: feedback returns register, pin or nothing.
// - JK or SR: eight terms split over two OR gates feeding both inputs.
// - JK or SR: only register feedback or none; pin feedback unavailable.
// - no output plus pin feedback makes the pin a dedicated input.
// - erased state: combinatorial, active-low output, pin feedback.
// - lock bit hides configuration from readback; erase clears it too.
// - power-down disable bit keeps the cell out of standby forever.
// - otherwise standby follows about 100 ns without any transition.
// - mode 0 enables on term high, floats on low; mode 0 is erased default.
//
// Added by the designer: the APB register port and the register offsets.
`timescale 1ns/1ns
module mcl_macrocell
  import mcl_pkg::*;
#(
  parameter int NPT      = MCL_NPT,
  parameter int IDLE_CYC = MCL_STANDBY_CYC
) (
  input  wire logic           pclk,
  input  wire logic           presetn,
  // apb slave
  input  wire logic           psel,
  input  wire logic           penable,
  input  wire logic           pwrite,
  input  wire logic [7:0]     paddr,
  input  wire logic [31:0]    pwdata,
  output logic      [31:0]    prdata,
  output logic                pready,
  output logic                pslverr,
  // and array side, same clock domain
  input  wire logic [NPT-1:0] logic_pt,
  input  wire logic           clear_pt,
  input  wire logic           oeclk_pt,
  // pins
  input  wire logic           global_clk,
  input  wire logic           io_in,
  output logic                io_out,
  output logic                io_oe,
  // back to the and array
  output logic                feedback,
  output logic                feedback_valid,
  output logic                standby
);

  localparam int SW = MCL_CFG_SPLIT_W;

  typedef struct packed {
    logic [MCL_CFG_W-1:0] cfg;
    logic [1:0]           dev;
    logic                 q;
    logic [2:0]           pin_sync;
    logic                 pin_lvl;
    logic [2:0]           gclk_sync;
    logic                 gclk_lvl;
    logic                 oeclk_q;
    logic [NPT-1:0]       pt_q;
    logic                 clear_q;
    logic                 io_out;
    logic                 io_oe;
    logic                 feedback;
    logic                 feedback_valid;
    logic [31:0]          prdata;
    logic                 pready;
    logic                 pslverr;
  } mcl_state_t;

  mcl_state_t st;
  mcl_state_t next_st;
  logic       activity;
  logic       standby_i;

  ////////////////////////////////////////////////////////////////////////
  // or of the terms whose index lies in [lo, hi)
  function automatic logic or_range(input logic [NPT-1:0] pt, input int lo, input int hi);
    logic r;
    r = 1'b0;
    for (int i = 0; i < NPT; i++) begin
      if (i >= lo && i < hi) begin
        r = r | pt[i];
      end
    end
    return r;
  endfunction

  // registered apb read value for an offset
  function automatic logic [32:0] read_word(input mcl_state_t s, input logic [7:0] a, input logic sb);
    logic [32:0] r;
    r = '0;
    case (a)
      MCL_OFS_CFG: begin
        // a locked part answers zero rather than an error, so probes learn nothing
        if (!s.dev[MCL_DEV_LOCK]) begin
          r[MCL_CFG_W-1:0] = s.cfg;
        end
      end
      MCL_OFS_DEVICE: begin
        r[1:0] = s.dev;
      end
      MCL_OFS_CTRL: begin
        r = '0;
      end
      MCL_OFS_STATUS: begin
        r[MCL_ST_Q]       = s.q;
        r[MCL_ST_PIN]     = s.pin_lvl;
        r[MCL_ST_STANDBY] = sb;
        r[MCL_ST_OE]      = s.io_oe;
        r[MCL_ST_OUT]     = s.io_out;
      end
      default: begin
        r[32] = 1'b1;
      end
    endcase
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  logic [MCL_CFG_W-1:0] c;
  mcl_kind_t            kind;
  logic [SW-1:0]        split;
  logic [1:0]           fb_sel;
  logic                 sum_all;
  logic                 in_a;
  logic                 in_b;
  logic                 reg_clk;
  logic                 q_new;
  logic                 src;
  logic [32:0]          rd;
  logic                 gclk_rise;
  logic                 pt_rise;

  always_comb begin
    next_st   = st;
    c         = st.cfg;
    kind      = mcl_kind_t'(c[MCL_CFG_KIND_LSB +: MCL_CFG_KIND_W]);
    split     = c[MCL_CFG_SPLIT_LSB +: SW];
    fb_sel    = c[MCL_CFG_FB_LSB +: MCL_CFG_FB_W];
    rd        = '0;
    q_new     = st.q;
    src       = 1'b0;
    reg_clk   = 1'b0;

    // pin inputs: three stages, a change counts once stages two and three agree
    next_st.pin_sync  = {st.pin_sync[1:0], io_in};
    next_st.gclk_sync = {st.gclk_sync[1:0], global_clk};
    if (st.pin_sync[2] == st.pin_sync[1]) begin
      next_st.pin_lvl = st.pin_sync[1];
    end
    if (st.gclk_sync[2] == st.gclk_sync[1]) begin
      next_st.gclk_lvl = st.gclk_sync[1];
    end
    gclk_rise = (st.gclk_sync[2] == st.gclk_sync[1]) && st.gclk_sync[1] && !st.gclk_lvl;
    pt_rise   = oeclk_pt && !st.oeclk_q;
    next_st.oeclk_q = oeclk_pt;
    next_st.pt_q    = logic_pt;
    next_st.clear_q = clear_pt;

    // product-term sums
    sum_all = or_range(logic_pt, 0, NPT);
    in_a    = or_range(logic_pt, 0, int'(split));
    in_b    = or_range(logic_pt, int'(split), NPT);

    // register clock source
    reg_clk = c[MCL_CFG_OECLK] ? pt_rise : gclk_rise;

    case (kind)
      MCL_KIND_DT: begin
        if (reg_clk) begin
          q_new = c[MCL_CFG_TSEL] ? (st.q ^ sum_all) : sum_all;
        end
      end
      MCL_KIND_JKSR: begin
        if (reg_clk) begin
          if (c[MCL_CFG_SRSEL]) begin
            // set and reset together resolve to low
            q_new = in_a && !in_b ? 1'b1 : (in_b ? 1'b0 : st.q);
          end else begin
            q_new = (in_a && in_b) ? !st.q : (in_a ? 1'b1 : (in_b ? 1'b0 : st.q));
          end
        end
      end
      default: begin
        q_new = 1'b0;
      end
    endcase
    // clear beats any clock in the same cycle; the term itself is not sampled on an edge
    if (clear_pt && kind != MCL_KIND_COMB) begin
      q_new = 1'b0;
    end
    next_st.q = q_new;

    // output value, polarity and enable
    src = (kind == MCL_KIND_COMB) ? sum_all : q_new;
    next_st.io_out = c[MCL_CFG_INVERT] ? !src : src;
    if (c[MCL_CFG_OUTNONE]) begin
      next_st.io_oe = 1'b0;
    end else if (kind == MCL_KIND_COMB || !c[MCL_CFG_OECLK]) begin
      next_st.io_oe = oeclk_pt;
    end else begin
      next_st.io_oe = 1'b1;
    end

    // feedback selector; codes a configuration cannot offer fall back to none
    next_st.feedback       = 1'b0;
    next_st.feedback_valid = 1'b0;
    if (fb_sel == MCL_FB_PIN && kind != MCL_KIND_JKSR) begin
      next_st.feedback       = next_st.pin_lvl;
      next_st.feedback_valid = 1'b1;
    end else if (fb_sel == MCL_FB_REG && kind != MCL_KIND_COMB) begin
      next_st.feedback       = q_new;
      next_st.feedback_valid = 1'b1;
    end

    // apb: answer is prepared in setup and shown in the first access cycle
    next_st.pready  = 1'b0;
    next_st.pslverr = 1'b0;
    if (psel && !penable) begin
      rd              = read_word(st, paddr, standby_i);
      next_st.pready  = 1'b1;
      next_st.pslverr = rd[32];
      next_st.prdata  = pwrite ? 32'h0000_0000 : rd[31:0];
    end
    if (psel && penable && st.pready && pwrite && !st.pslverr) begin
      case (paddr)
        MCL_OFS_CFG: begin
          next_st.cfg = pwdata[MCL_CFG_W-1:0];
        end
        MCL_OFS_DEVICE: begin
          next_st.dev = pwdata[1:0];
        end
        MCL_OFS_CTRL: begin
          if (pwdata[MCL_CTRL_ERASE]) begin
            next_st.cfg = MCL_CFG_ERASED;
            next_st.dev = MCL_DEV_ERASED;
          end
        end
        default: begin
          next_st.cfg = st.cfg;
        end
      endcase
    end
  end

  // any transition seen by the cell keeps it awake
  assign activity = (logic_pt != st.pt_q) || (clear_pt != st.clear_q) || pt_rise ||
                    (oeclk_pt != st.oeclk_q) || (next_st.pin_lvl != st.pin_lvl) ||
                    (next_st.gclk_lvl != st.gclk_lvl);

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st        <= '0;
      st.cfg    <= MCL_CFG_ERASED;
      st.dev    <= MCL_DEV_ERASED;
      st.q      <= 1'b0;
      st.io_out <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  mcl_idle_timer #(
    .IDLE_CYC (IDLE_CYC)
  ) u_idle (
    .pclk       (pclk),
    .presetn    (presetn),
    .activity   (activity),
    .pd_disable (st.dev[MCL_DEV_PDDIS]),
    .standby    (standby_i)
  );

  ////////////////////////////////////////////////////////////////////////
  assign prdata         = st.prdata;
  assign pready         = st.pready;
  assign pslverr        = st.pslverr;
  assign io_out         = st.io_out;
  assign io_oe          = st.io_oe;
  assign feedback       = st.feedback;
  assign feedback_valid = st.feedback_valid;
  assign standby        = standby_i;

endmodule

// ==== verification/mcl_macrocell_checker.sv ====
// assertion checker for the configurable output macrocell
`timescale 1ns/1ns
module mcl_macrocell_checker
  import mcl_pkg::*;
#(
  parameter int NPT = MCL_NPT
) (
  input wire logic           pclk,
  input wire logic           presetn,
  input wire logic           psel,
  input wire logic           penable,
  input wire logic           pwrite,
  input wire logic [7:0]     paddr,
  input wire logic [31:0]    pwdata,
  input wire logic [31:0]    prdata,
  input wire logic           pready,
  input wire logic           pslverr,
  input wire logic [NPT-1:0] logic_pt,
  input wire logic           clear_pt,
  input wire logic           oeclk_pt,
  input wire logic           global_clk,
  input wire logic           io_in,
  input wire logic           io_out,
  input wire logic           io_oe,
  input wire logic           feedback,
  input wire logic           feedback_valid,
  input wire logic           standby
);
  logic [MCL_CFG_W-1:0] cfg;
  logic [MCL_CFG_W-1:0] cfg_d;
  logic [1:0]           dev;
  logic                 pd_q;
  logic                 live;
  logic                 wr_en;
  logic                 steady;
  logic                 regk;
  logic                 comb;
  // configuration is internal, so a shadow copy follows committed writes
  assign wr_en  = psel && penable && pready && pwrite;
  assign steady = live && (cfg == cfg_d);
  assign comb   = cfg[2:0] == MCL_KIND_COMB;
  assign regk   = (cfg[2:0] == MCL_KIND_DT) || (cfg[2:0] == MCL_KIND_JKSR);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg   <= MCL_CFG_ERASED;
      dev   <= MCL_DEV_ERASED;
      cfg_d <= MCL_CFG_ERASED;
      pd_q  <= 1'b0;
      live  <= 1'b0;
    end else begin
      cfg_d <= cfg;
      pd_q  <= dev[MCL_DEV_PDDIS];
      live  <= 1'b1;
      if (wr_en && paddr == MCL_OFS_CFG) cfg <= pwdata[MCL_CFG_W-1:0];
      if (wr_en && paddr == MCL_OFS_DEVICE) dev <= pwdata[1:0];
      if (wr_en && paddr == MCL_OFS_CTRL && pwdata[MCL_CTRL_ERASE]) begin
        cfg <= MCL_CFG_ERASED;
        dev <= MCL_DEV_ERASED;
      end
    end
  end
  default clocking dc @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////////////
  setup_answer_a: assert property (psel && !penable |=> pready &&
    (pslverr == !($past(paddr) inside {8'h00, 8'h04, 8'h08, 8'h0c}))) else $error("bad apb answer");
  ready_pulse_a: assert property (pready |=> !pready) else $error("pready too long");
  comb_output_a: assert property (steady && comb && !cfg[MCL_CFG_OUTNONE] |->
    io_out == ((|$past(logic_pt)) ^ cfg[MCL_CFG_INVERT])) else $error("comb output wrong");
  oe_select_a: assert property (steady && !cfg[MCL_CFG_OUTNONE] |->
    io_oe == ($past(oeclk_pt) || (regk && cfg[MCL_CFG_OECLK]))) else $error("output enable wrong");
  pin_input_a: assert property (steady && cfg[MCL_CFG_OUTNONE] |-> !io_oe) else $error("input pin driven");
  clear_low_a: assert property (steady && regk && !cfg[MCL_CFG_OUTNONE] && $past(clear_pt) && $past(clear_pt, 2) |->
    io_out == cfg[MCL_CFG_INVERT] && !(cfg[8:7] == MCL_FB_REG && feedback)) else $error("clear ignored");
  fb_source_a: assert property (steady |-> feedback_valid ==
    ((cfg[8:7] == MCL_FB_PIN && cfg[2:0] != MCL_KIND_JKSR) || (cfg[8:7] == MCL_FB_REG && !comb)))
    else $error("feedback source wrong");
  pd_no_standby_a: assert property (dev[MCL_DEV_PDDIS] && pd_q |=> !standby) else $error("standby while disabled");
  wake_on_change_a: assert property (standby && $changed(logic_pt) |-> ##[1:2] !standby)
    else $error("standby kept after activity");
endmodule
////////////////////////////////////////////////////////////////////////
bind mcl_macrocell mcl_macrocell_checker #(.NPT(NPT)) u_mcl_macrocell_checker (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .logic_pt(logic_pt),
  .clear_pt(clear_pt), .oeclk_pt(oeclk_pt), .global_clk(global_clk), .io_in(io_in), .io_out(io_out),
  .io_oe(io_oe), .feedback(feedback), .feedback_valid(feedback_valid), .standby(standby));

// ==== verification/tb.sv ====
// self-checking bench for the configurable output macrocell
`timescale 1ns/1ns
module tb;
  import mcl_pkg::*;
  typedef struct packed {
    logic [13:0] cfg;
    logic [7:0]  pt;
    logic        oe_pt;
    logic        pin;
    logic        out;
    logic        oe;
    logic        fbv;
  } mcl_row_t;
  logic        pclk, presetn, psel, penable, pwrite, clear_pt, oeclk_pt, global_clk, io_in;
  logic [7:0]  paddr;
  logic [7:0]  logic_pt;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, io_out, io_oe, feedback, feedback_valid, standby;
  int          error_cnt, tests_run, cyc;
  mcl_row_t    rows [6] = '{
    '{14'h00a1, 8'h00, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1}, '{14'h00a1, 8'h80, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1},
    '{14'h0081, 8'h01, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1}, '{14'h0001, 8'h00, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0},
    '{14'h0101, 8'h10, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0}, '{14'h0281, 8'h00, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1}};
  // short idle count keeps the standby wait brief
  mcl_macrocell #(.IDLE_CYC(5)) u_mcl_macrocell (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .logic_pt(logic_pt),
    .clear_pt(clear_pt), .oeclk_pt(oeclk_pt), .global_clk(global_clk), .io_in(io_in), .io_out(io_out),
    .io_oe(io_oe), .feedback(feedback), .feedback_valid(feedback_valid), .standby(standby));
  always #2 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      complete_run();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task complete_run;
    if (error_cnt == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r, output logic s);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    s = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] d, input logic e);
    logic [31:0] r;
    logic        s;
    apb(1'b0, a, 32'h0, r, s);
    chk("prdata", d, r);
    chk("pslverr", e, s);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        s;
    apb(1'b1, a, d, r, s);
  endtask
  task pins(input logic o, input logic e, input logic f);
    chk("io_out", o, io_out);
    chk("io_oe", e, io_oe);
    chk("feedback", f, feedback);
  endtask
  // the synchroniser needs several cycles on each level of the pin
  task gtick(input logic [7:0] pt);
    logic_pt   <= pt;
    global_clk <= 1'b1;
    repeat (5) @(posedge pclk);
    global_clk <= 1'b0;
    repeat (5) @(posedge pclk);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    {pclk, presetn, psel, penable, pwrite, clear_pt, oeclk_pt, global_clk, io_in} = '0;
    {paddr, logic_pt, pwdata} = '0;
    repeat (5) @(posedge pclk);
    chk("io_oe", 1'b0, io_oe);
    presetn <= 1'b1;
    foreach (rows[i]) begin
      wr(MCL_OFS_CFG, 32'(rows[i].cfg));
      logic_pt <= rows[i].pt;
      oeclk_pt <= rows[i].oe_pt;
      io_in    <= rows[i].pin;
      repeat (6) @(posedge pclk);
      if (!rows[i].cfg[MCL_CFG_OUTNONE]) chk("io_out", rows[i].out, io_out);
      chk("io_oe", rows[i].oe, io_oe);
      chk("feedback_valid", rows[i].fbv, feedback_valid);
      if (rows[i].fbv) chk("feedback", rows[i].pin, feedback);
    end
    rd(8'h10, 32'h0, 1'b1);
    wr(MCL_OFS_CTRL, 32'h1);
    rd(MCL_OFS_CFG, 32'(MCL_CFG_ERASED), 1'b0);
    wr(MCL_OFS_DEVICE, 32'h1);
    rd(MCL_OFS_CFG, 32'h0, 1'b0);
    rd(MCL_OFS_DEVICE, 32'h1, 1'b0);
    wr(MCL_OFS_CTRL, 32'h1);
    rd(MCL_OFS_DEVICE, 32'h0, 1'b0);
    // d register: clear, then wait for the global edge
    wr(MCL_OFS_CFG, 32'h0102);
    oeclk_pt <= 1'b1;
    logic_pt <= 8'h01;
    clear_pt <= 1'b1;
    repeat (3) @(posedge pclk);
    pins(1'b0, 1'b1, 1'b0);
    clear_pt <= 1'b0;
    repeat (4) @(posedge pclk);
    pins(1'b0, 1'b1, 1'b0);
    gtick(8'h01);
    pins(1'b1, 1'b1, 1'b1);
    wr(MCL_OFS_CFG, 32'h010a);
    gtick(8'h01);
    pins(1'b0, 1'b1, 1'b0);
    wr(MCL_OFS_CFG, 32'h014a);
    oeclk_pt <= 1'b0;
    repeat (3) @(posedge pclk);
    pins(1'b0, 1'b1, 1'b0);
    oeclk_pt <= 1'b1;
    repeat (3) @(posedge pclk);
    pins(1'b1, 1'b1, 1'b1);
    gtick(8'h01);
    pins(1'b1, 1'b1, 1'b1);
    // jk split at four, then at two
    wr(MCL_OFS_CFG, 32'h1104);
    gtick(8'h10);
    pins(1'b0, 1'b1, 1'b0);
    gtick(8'h01);
    pins(1'b1, 1'b1, 1'b1);
    gtick(8'h11);
    pins(1'b0, 1'b1, 1'b0);
    wr(MCL_OFS_CFG, 32'h0904);
    gtick(8'h01);
    gtick(8'h04);
    pins(1'b0, 1'b1, 1'b0);
    wr(MCL_OFS_CFG, 32'h1114);
    gtick(8'h01);
    pins(1'b1, 1'b1, 1'b1);
    wr(MCL_OFS_CFG, 32'h1084);
    repeat (3) @(posedge pclk);
    chk("feedback_valid", 1'b0, feedback_valid);
    repeat (12) @(posedge pclk);
    chk("standby", 1'b1, standby);
    logic_pt <= 8'h00;
    repeat (3) @(posedge pclk);
    chk("standby", 1'b0, standby);
    wr(MCL_OFS_DEVICE, 32'h2);
    repeat (12) @(posedge pclk);
    chk("standby", 1'b0, standby);
    // mid-run reset: outputs return to the erased state at once
    presetn <= 1'b0;
    @(posedge pclk);
    pins(1'b1, 1'b0, 1'b0);
    chk("standby", 1'b0, standby);
    presetn <= 1'b1;
    // status: q low, pin not yet synced, awake, enabled by term, inverted zero
    rd(MCL_OFS_STATUS, 32'h0000_0018, 1'b0);
    rd(MCL_OFS_DEVICE, 32'h0, 1'b0);
    complete_run();
  end
endmodule
